// ### shared/sb0_defs.vh
// Register indices, field positions, reset values and event codes of bank 0.
// Assumes it is included by bare name from every design file that needs it.
`ifndef SB0_DEFS_VH
`define SB0_DEFS_VH

// ************************************************************
// Register indices (byte address is index shifted left by two)
// ************************************************************
`define SB0_IDX_DATA 4'h0
`define SB0_IDX_IRQ_EN 4'h1
`define SB0_IDX_EVENT 4'h2
`define SB0_IDX_LINE_CTL 4'h3
`define SB0_IDX_MODEM_CTL 4'h4
`define SB0_IDX_LINE_STAT 4'h5
`define SB0_IDX_MODEM_STAT 4'h6
`define SB0_IDX_SCRATCH 4'h7
`define SB0_IDX_MODE 4'h8
`define SB0_IDX_LSB 2

// ************************************************************
// Field positions
// ************************************************************
`define SB0_MODE_EXT 0
`define SB0_MODE_CIR 1
`define SB0_QC_FIFO_EN 0
`define SB0_QC_RX_CLR 1
`define SB0_QC_TX_CLR 2
`define SB0_LC_BANK 7
`define SB0_MC_DMA_EN 2
`define SB0_MS_RI 2

// ************************************************************
// Reset values and masks
// ************************************************************
`define SB0_ZERO8 8'h00
`define SB0_IRQ_EN_MASK_STD 8'h0f
`define SB0_IRQ_EN_MASK_EXT 8'h3f

// ************************************************************
// Event identification codes, non-extended layout
// ************************************************************
`define SB0_ID_NONE 4'h1
`define SB0_ID_LINE 4'h6
`define SB0_ID_RX_LEVEL 4'h4
`define SB0_ID_RX_TIMEOUT 4'hc
`define SB0_ID_TX_LOW 4'h2
`define SB0_ID_MODEM 4'h0

// ************************************************************
// Queue thresholds
// ************************************************************
`define SB0_RX_THR0 5'h01
`define SB0_RX_THR1 5'h04
`define SB0_RX_THR2 5'h08
`define SB0_RX_THR3 5'h0e
`define SB0_TX_THR 5'h04

`endif

// ### hw/sb0_queue.v
// Byte queue held in flip-flops, used for both receive and transmit data.
// Assumes pushes when full and pops when empty may be dropped.
`timescale 1ns/1ps
module sb0_queue #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire rstn,
    input wire clear,
    input wire push,
    input wire [WIDTH-1:0] din,
    input wire pop,
    output wire [WIDTH-1:0] dout,
    output wire [AW:0] count
);
    localparam [AW:0] FULL = DEPTH[AW:0];
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] cnt;
    wire do_push = push && (cnt != FULL);
    wire do_pop = pop && (cnt != {(AW+1){1'b0}});

    assign dout = mem[rd_ptr];
    assign count = cnt;

    always @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr] <= din;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            cnt <= {(AW+1){1'b0}};
        end else if (clear) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            cnt <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                cnt <= cnt + 1'b1;
            end else if (do_pop && !do_push) begin
                cnt <= cnt - 1'b1;
            end
        end
    end
endmodule

// ### hw/sb0_irq_prio.v
// Five-level priority encoder for the legacy event code.
// Assumes every input is already gated by its enable bit.
`include "sb0_defs.vh"
`timescale 1ns/1ps
module sb0_irq_prio (
    input wire line_ev,
    input wire rx_level_ev,
    input wire rx_timeout_ev,
    input wire tx_low_ev,
    input wire modem_ev,
    output reg [3:0] event_id
);
    always @* begin
        if (line_ev) begin
            event_id = `SB0_ID_LINE; // [R20]
        end else if (rx_timeout_ev) begin
            event_id = `SB0_ID_RX_TIMEOUT; // [R8]
        end else if (rx_level_ev) begin
            event_id = `SB0_ID_RX_LEVEL; // [R8]
        end else if (tx_low_ev) begin
            event_id = `SB0_ID_TX_LOW; // [R9]
        end else if (modem_ev) begin
            event_id = `SB0_ID_MODEM; // [R11]
        end else begin
            event_id = `SB0_ID_NONE;
        end
    end
endmodule

// ### hw/sb0_bank0.v
// Bank 0 control of a serial port: data port, queues, enables, events, interrupt line.
// Assumes APB master, receiver, transmitter and DMA all on pclk;
// DMA strobes last one cycle.
//
// Behaviour
// [R1] Reset selects legacy mode: no queues, no extended features.
// [R2] Eight byte registers at indices 0..7; index 0 read is receive, write transmit.
// [R3] Data port read gives the holding byte, or the oldest queued byte.
// [R4] Data port write loads the holding byte, or pushes onto the transmit queue.
// [R5] DMA strobes reach the data ports whatever bank is selected.
// [R6] Enable bits 4..7 are writable only in extended mode, else held at zero.
// [R7] Reset clears every enable bit.
// [R8] Legacy: enable bit 0 gates receive level and receive time-out, codes 0100, 1100.
// [R9] Legacy: enable bit 1 gates transmit low level, code 0010.
// [R10] Legacy: enable bit 2 gates line status, code 0110.
// [R11] Legacy: enable bit 3 gates modem status, code 0000.
// [R12] Extended: bit 0 gates receive level at threshold or receive time-out.
// [R13] Extended: bit 1 gates transmit queue below threshold or holding empty.
// [R14] Extended: bits 2 and 3 gate line and modem status; bits 6, 7 reserved.
// [R15] Extended: bit 4 gates DMA terminal count while DMA is enabled.
// [R16] Extended: bit 5 gates transmitter and transmit queue both empty.
// [R17] Consumer infrared: bits 1 and 0 behave as in extended modes.
// [R18] Software clears the enables in an edge-triggered service routine.
// [R19] Software keeps self-clearing source enables at zero while polling.
// [R20] Legacy pending events rank line, receive, transmit, modem.
// [R21] Consumer infrared: bit 2 gates receive overrun and transmit underrun.
// [R22] Interrupt output is high only while an enabled event is pending.
//
// Implementation choice: the APB slave port.
`include "sb0_defs.vh"
`timescale 1ns/1ps
module sb0_bank0 #(
    parameter ADDR_W = 6,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire rx_byte_valid,
    input wire [7:0] rx_byte,
    input wire [2:0] rx_err,
    input wire rx_timeout,
    output reg [7:0] tx_data,
    output reg tx_valid,
    input wire tx_ready,
    input wire tx_shift_empty,
    input wire tx_underrun,
    input wire [3:0] modem_lines,
    input wire dma_rx_rd,
    output reg [7:0] dma_rx_data,
    input wire dma_tx_wr,
    input wire [7:0] dma_tx_data,
    input wire dma_tc,
    output reg irq
);
    // ************************************************************
    // Thresholds
    // ************************************************************
    function [AW:0] rx_thr;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: rx_thr = `SB0_RX_THR0;
                2'h1: rx_thr = `SB0_RX_THR1;
                2'h2: rx_thr = `SB0_RX_THR2;
                default: rx_thr = `SB0_RX_THR3;
            endcase
        end
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    reg [1:0] mode;
    reg [7:0] irq_enable;
    reg fifo_en;
    reg [1:0] rx_thr_sel;
    reg [7:0] line_control;
    reg [7:0] modem_control;
    reg [7:0] scratch;
    reg oe_flag;
    reg [2:0] err_flags;
    reg line_stat_event;
    reg [3:0] modem_delta;
    reg [3:0] modem_prev;
    reg rx_to_flag;
    reg tx_low_flag;
    reg tx_empty_prev;
    reg dma_ev;
    reg [3:0] acc_idx;
    reg acc_bad;

    wire ext_mode = mode[`SB0_MODE_EXT];
    wire cir_mode = mode[`SB0_MODE_CIR];
    wire ext_layout = ext_mode | cir_mode;
    wire [3:0] idx = paddr[`SB0_IDX_LSB+3:`SB0_IDX_LSB];
    wire bank0 = ~line_control[`SB0_LC_BANK];
    wire setup = psel & ~penable;
    wire done = psel & penable & pready;
    wire wr_done = done & pwrite & ~acc_bad;
    wire rd_done = done & ~pwrite & ~acc_bad;
    wire [7:0] wbyte = pwdata[7:0];

    // ************************************************************
    // Queues
    // ************************************************************
    wire [7:0] rx_head;
    wire [7:0] tx_head;
    wire [AW:0] rx_cnt;
    wire [AW:0] tx_cnt;
    wire [AW:0] one = {{AW{1'b0}}, 1'b1};
    // Queues off: the holding register is a one-entry queue
    wire [AW:0] limit = fifo_en ? DEPTH[AW:0] : one;
    wire rx_full = (rx_cnt >= limit);
    wire rx_empty = (rx_cnt == {(AW+1){1'b0}});
    wire tx_empty = (tx_cnt == {(AW+1){1'b0}});
    wire host_rx_pop = rd_done && (acc_idx == `SB0_IDX_DATA); // [R2] [R3]
    wire host_tx_push = wr_done && (acc_idx == `SB0_IDX_DATA); // [R2] [R4]
    wire rx_pop = host_rx_pop | dma_rx_rd; // [R5]
    wire tx_room = (tx_cnt < limit);
    wire tx_push = (host_tx_push | dma_tx_wr) & tx_room; // [R4] [R5]
    wire [7:0] tx_in = host_tx_push ? wbyte : dma_tx_data;
    wire rx_push = rx_byte_valid & ~rx_full;
    wire tx_load = ~tx_empty & (~tx_valid | tx_ready);
    wire qc_wr = wr_done && (acc_idx == `SB0_IDX_EVENT);
    wire qc_toggle = qc_wr && (wbyte[`SB0_QC_FIFO_EN] != fifo_en);
    wire rx_clr = qc_wr & (wbyte[`SB0_QC_RX_CLR] | qc_toggle);
    wire tx_clr = qc_wr & (wbyte[`SB0_QC_TX_CLR] | qc_toggle);

    sb0_queue #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_rx_queue (
        .clk(pclk),
        .rstn(presetn),
        .clear(rx_clr),
        .push(rx_push),
        .din(rx_byte),
        .pop(rx_pop),
        .dout(rx_head),
        .count(rx_cnt)
    );

    sb0_queue #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_tx_queue (
        .clk(pclk),
        .rstn(presetn),
        .clear(tx_clr),
        .push(tx_push),
        .din(tx_in),
        .pop(tx_load),
        .dout(tx_head),
        .count(tx_cnt)
    );

    // ************************************************************
    // Events and enable gating
    // ************************************************************
    wire rx_level = fifo_en ? (rx_cnt >= rx_thr(rx_thr_sel)) : ~rx_empty;
    wire tx_level = fifo_en ? (tx_cnt < `SB0_TX_THR) : tx_empty;
    wire tx_all_empty = tx_empty & ~tx_valid & tx_shift_empty;
    wire modem_ev = |modem_delta;
    wire tx_low_src = ext_layout ? tx_level : tx_low_flag;
    wire g_rx_level = irq_enable[0] & rx_level; // [R8] [R12] [R17]
    wire g_rx_to = irq_enable[0] & rx_to_flag; // [R8] [R12] [R17]
    wire g_tx = irq_enable[1] & tx_low_src; // [R9] [R13] [R17]
    wire g_line = irq_enable[2] & line_stat_event; // [R10] [R14] [R21]
    wire g_modem = irq_enable[3] & modem_ev; // [R11] [R14]
    wire g_dma = ext_layout & irq_enable[4] & dma_ev; // [R15]
    wire g_txe = ext_layout & irq_enable[5] & tx_all_empty; // [R16]
    wire any_irq = g_rx_level | g_rx_to | g_tx | g_line | g_modem | g_dma | g_txe;
    wire [3:0] legacy_id;

    sb0_irq_prio u_prio (
        .line_ev(g_line),
        .rx_level_ev(g_rx_level),
        .rx_timeout_ev(g_rx_to),
        .tx_low_ev(g_tx),
        .modem_ev(g_modem),
        .event_id(legacy_id)
    );

    // ************************************************************
    // Register read mux
    // ************************************************************
    reg [7:0] rd_byte;
    reg rd_bad;
    always @* begin
        rd_byte = `SB0_ZERO8;
        rd_bad = 1'b0;
        if (paddr[`SB0_IDX_LSB-1:0] != {`SB0_IDX_LSB{1'b0}} || idx > `SB0_IDX_MODE) begin
            rd_bad = 1'b1;
        end else if (!bank0 && idx != `SB0_IDX_LINE_CTL && idx != `SB0_IDX_MODE) begin
            rd_bad = 1'b1;
        end else begin
            case (idx)
                `SB0_IDX_DATA: rd_byte = rx_head; // [R3]
                `SB0_IDX_IRQ_EN: rd_byte = irq_enable;
                `SB0_IDX_EVENT: begin
                    if (ext_layout) begin
                        rd_byte = {2'b00, tx_all_empty, dma_ev, modem_ev,
                            line_stat_event, tx_level, rx_level | rx_to_flag};
                    end else begin
                        rd_byte = {{2{fifo_en}}, 2'b00, legacy_id}; // [R20]
                    end
                end
                `SB0_IDX_LINE_CTL: rd_byte = line_control;
                `SB0_IDX_MODEM_CTL: rd_byte = modem_control;
                `SB0_IDX_LINE_STAT: begin
                    rd_byte = {1'b0, tx_all_empty, tx_empty, err_flags, oe_flag, ~rx_empty};
                end
                `SB0_IDX_MODEM_STAT: rd_byte = {modem_lines, modem_delta};
                `SB0_IDX_SCRATCH: rd_byte = ext_layout ? {7'h00, rx_to_flag} : scratch;
                `SB0_IDX_MODE: rd_byte = {6'h00, mode};
                default: rd_bad = 1'b1;
            endcase
        end
    end

    // ************************************************************
    // APB slave: one access cycle, answer registered at setup
    // ************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            acc_idx <= 4'h0;
            acc_bad <= 1'b0;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata <= {24'h000000, pwrite ? `SB0_ZERO8 : rd_byte};
                pslverr <= rd_bad;
                acc_idx <= idx;
                acc_bad <= rd_bad;
            end else if (done) begin
                pslverr <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= 2'b00; // [R1]
            irq_enable <= `SB0_ZERO8; // [R7]
            fifo_en <= 1'b0; // [R1]
            rx_thr_sel <= 2'b00;
            line_control <= `SB0_ZERO8;
            modem_control <= `SB0_ZERO8;
            scratch <= `SB0_ZERO8;
        end else begin
            if (wr_done) begin
                case (acc_idx)
                    `SB0_IDX_IRQ_EN: begin
                        irq_enable <= wbyte & (ext_layout ? `SB0_IRQ_EN_MASK_EXT
                            : `SB0_IRQ_EN_MASK_STD); // [R6] [R14]
                    end
                    `SB0_IDX_EVENT: begin
                        fifo_en <= wbyte[`SB0_QC_FIFO_EN];
                        rx_thr_sel <= wbyte[7:6];
                    end
                    `SB0_IDX_LINE_CTL: line_control <= wbyte;
                    `SB0_IDX_MODEM_CTL: modem_control <= wbyte;
                    `SB0_IDX_SCRATCH: scratch <= wbyte;
                    `SB0_IDX_MODE: mode <= wbyte[1:0];
                    default: mode <= mode;
                endcase
            end else if (!ext_layout) begin
                irq_enable[7:4] <= 4'h0; // [R6]
            end
        end
    end

    // ************************************************************
    // Sticky status flags; a set in the clearing cycle wins
    // ************************************************************
    wire ls_rd = rd_done && (acc_idx == `SB0_IDX_LINE_STAT);
    wire ms_rd = rd_done && (acc_idx == `SB0_IDX_MODEM_STAT);
    wire ev_rd = rd_done && (acc_idx == `SB0_IDX_EVENT);
    wire overrun = rx_byte_valid & rx_full;
    wire [2:0] err_in = rx_push ? rx_err : 3'b000;
    wire line_set = cir_mode ? (overrun | tx_underrun) : (overrun | (|err_in)); // [R21]
    wire [3:0] modem_chg = modem_lines ^ modem_prev;
    wire [3:0] modem_set = {modem_chg[3], modem_lines[`SB0_MS_RI] & ~modem_prev[`SB0_MS_RI],
        modem_chg[1:0]};
    wire tx_empty_rise = tx_empty & ~tx_empty_prev;
    wire dma_set = dma_tc & ext_layout & modem_control[`SB0_MC_DMA_EN]; // [R15]

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_flag <= 1'b0;
            err_flags <= 3'b000;
            line_stat_event <= 1'b0;
            modem_delta <= 4'h0;
            modem_prev <= 4'h0;
            rx_to_flag <= 1'b0;
            tx_low_flag <= 1'b0;
            tx_empty_prev <= 1'b1;
            dma_ev <= 1'b0;
        end else begin
            modem_prev <= modem_lines;
            tx_empty_prev <= tx_empty;
            oe_flag <= overrun | (oe_flag & ~ls_rd);
            err_flags <= err_in | (err_flags & {3{~ls_rd}});
            line_stat_event <= line_set | (line_stat_event & ~ls_rd);
            modem_delta <= modem_set | (modem_delta & {4{~ms_rd}});
            rx_to_flag <= (rx_timeout & fifo_en) | (rx_to_flag & ~rx_pop);
            // Legacy transmit low event clears on data write or on reading its own code
            tx_low_flag <= tx_empty_rise | (tx_low_flag & ~tx_push & ~host_tx_push
                & ~(ev_rd && !ext_layout && legacy_id == `SB0_ID_TX_LOW)); // [R9]
            dma_ev <= dma_set | (dma_ev & ~ev_rd);
        end
    end

    // ************************************************************
    // Data toward transmitter and DMA; interrupt line
    // ************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_data <= `SB0_ZERO8;
            tx_valid <= 1'b0;
            dma_rx_data <= `SB0_ZERO8;
            irq <= 1'b0;
        end else begin
            if (tx_load) begin
                tx_data <= tx_head;
                tx_valid <= 1'b1;
            end else if (tx_ready) begin
                tx_valid <= 1'b0;
            end
            if (dma_rx_rd) begin
                dma_rx_data <= rx_head; // [R5]
            end
            // Level output; edge-triggered hosts must drop enables while serving
            irq <= any_irq; // [R22] [R18] [R19]
        end
    end
endmodule

// ### sim/sb0_assertions.sv
// Checker of the bank 0 serial block; sees top-level ports only.
// Assumes a bind from the testbench top file and one clock, pclk.
`timescale 1ns/1ps
module sb0_assertions #(
    parameter ADDR_W = 6
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [7:0] tx_data,
    input wire tx_valid,
    input wire tx_ready,
    input wire irq
);
    // ************************************************************
    // Shadow of the enable byte, so irq can be tied to its cause
    // ************************************************************
    reg [7:0] en_seen;
    wire wr_done = psel && penable && pready && pwrite && !pslverr;
    wire idx0 = paddr[5:2] == 4'h0;
    wire idx1 = paddr[5:2] == 4'h1;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_seen <= 8'h00;
        end else if (wr_done && idx1) begin
            en_seen <= pwdata[7:0];
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ************************************************************
    // Properties
    // ************************************************************
    setup_answer_a: assert property (psel && !penable |=> pready)
        else $error("setup not answered");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready stands too long");
    unmapped_err_a: assert property (psel && !penable && !pwrite && paddr[5:2] > 4'h8
        |=> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
    byte_only_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    enable_rsvd_a: assert property (pready && !pwrite && idx1 && !pslverr
        |-> prdata[7:6] == 2'b00) else $error("reserved enable bits set");
    tx_load_a: assert property (wr_done && idx0 && !tx_valid
        |=> ##1 tx_valid && tx_data == $past(pwdata[7:0], 2)) else $error("byte not sent");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("byte dropped in stall");
    quiet_irq_a: assert property ((en_seen == 8'h00) [*3] |-> !irq)
        else $error("irq with all enables clear");
    reset_quiet_a: assert property ($rose(presetn) |-> !irq && !tx_valid && !pready)
        else $error("outputs active after reset");

    cover property (wr_done && idx0);
    cover property (pready && pslverr);
    cover property ($rose(irq));
endmodule

// ### sim/sb0_link_model.sv
// Far-side model: a stallable transmit sink and a receive source.
// Assumes the testbench calls send_rx just after a rising edge of pclk.
`timescale 1ns/1ps
module sb0_link_model (
    input wire pclk,
    input wire presetn,
    input wire [7:0] tx_data,
    input wire tx_valid,
    output reg tx_ready = 1'b0,
    output reg tx_shift_empty = 1'b1,
    output reg rx_byte_valid = 1'b0,
    output reg [7:0] rx_byte = 8'h00,
    output reg [2:0] rx_err = 3'h0,
    input wire stall
);
    // ************************************************************
    // Transmit side
    // ************************************************************
    logic [7:0] got[$];
    always @(posedge pclk) begin
        tx_ready <= !stall && presetn;
        tx_shift_empty <= !(tx_valid && tx_ready);
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
        end
    end
    // ************************************************************
    // Receive side: data lines invert once the strobe is gone
    // ************************************************************
    task automatic send_rx(input [7:0] b, input [2:0] e);
        rx_byte_valid <= 1'b1;
        rx_byte <= b;
        rx_err <= e;
        @(posedge pclk);
        rx_byte_valid <= 1'b0;
        rx_byte <= ~b;
        rx_err <= ~e;
        @(posedge pclk);
    endtask
endmodule

// ### sim/test_serial_bank0_data_and_irq_enable.sv
// Testbench of the bank 0 serial block: APB tasks and scenario sequences.
// Assumes design, link model and checker are compiled alongside.
`timescale 1ns/1ps
`define CHK(g, w) begin compares++; if ((g) !== (w)) begin fails++; \
    $display("Error %0t: got %h want %h", $time, g, w); end end
module test_serial_bank0_data_and_irq_enable;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    reg pclk = 0;
    reg presetn = 0;
    reg psel = 0, penable = 0, pwrite = 0, stall = 0;
    reg dma_rx_rd = 0, dma_tx_wr = 0, dma_tc = 0;
    reg [5:0] paddr = 0;
    reg [31:0] pwdata = 0;
    reg [3:0] modem_lines = 0;
    reg [7:0] dma_tx_data = 0, rq;
    reg re;
    wire [31:0] prdata;
    wire pready, pslverr, tx_valid, tx_ready, tx_shift_empty, rx_byte_valid, irq;
    wire [7:0] tx_data, rx_byte, dma_rx_data;
    wire [2:0] rx_err;
    int fails = 0, compares = 0;
    sb0_bank0 sb0_bank0_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_err(rx_err),
        .rx_timeout(1'b0), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_shift_empty(tx_shift_empty), .tx_underrun(1'b0), .modem_lines(modem_lines),
        .dma_rx_rd(dma_rx_rd), .dma_rx_data(dma_rx_data), .dma_tx_wr(dma_tx_wr),
        .dma_tx_data(dma_tx_data), .dma_tc(dma_tc), .irq(irq));
    sb0_link_model sb0_link_model_inst (.pclk(pclk), .presetn(presetn), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_shift_empty(tx_shift_empty),
        .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_err(rx_err), .stall(stall));
    initial begin
        forever #2 pclk = ~pclk;
    end
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic acc(input w, input [3:0] i, input [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rq = prdata[7:0];
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input [3:0] i, input [7:0] d);
        acc(1'b1, i, d);
    endtask
    task automatic rd(input [3:0] i, input [7:0] w, input e);
        acc(1'b0, i, 8'h00);
        `CHK(rq, w)
        `CHK(re, e)
    endtask
    // Bounded so a dead irq fails instead of hanging
    task automatic wait_irq(input v);
        for (int n = 0; n < 8 && irq !== v; n++) @(negedge pclk);
        `CHK(irq, v)
        @(posedge pclk);
    endtask
    task automatic take_tx(input [7:0] w);
        int n;
        for (n = 0; n < 16 && sb0_link_model_inst.got.size() == 0; n++) @(posedge pclk);
        rq = (n < 16) ? sb0_link_model_inst.got.pop_front() : 8'h00;
        `CHK(rq, w)
    endtask
    task end_of_test;
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(4'h1, 8'h00, 1'b0);
        rd(4'h8, 8'h00, 1'b0);
        wr(4'h1, 8'hff);
        rd(4'h1, 8'h0f, 1'b0);
        wr(4'h8, 8'h01);
        wr(4'h1, 8'hff);
        rd(4'h1, 8'h3f, 1'b0);
        wr(4'h8, 8'h00);
        rd(4'h1, 8'h0f, 1'b0);
        wr(4'h1, 8'h05);
        sb0_link_model_inst.send_rx(8'h3c, 3'b001);
        wait_irq(1'b1);
        rd(4'h2, 8'h06, 1'b0);
        rd(4'h5, 8'h65, 1'b0);
        rd(4'h2, 8'h04, 1'b0);
        rd(4'h0, 8'h3c, 1'b0);
        wait_irq(1'b0);
        wr(4'h1, 8'h02);
        wr(4'h0, 8'ha5);
        take_tx(8'ha5);
        wait_irq(1'b1);
        rd(4'h2, 8'h02, 1'b0);
        rd(4'h2, 8'h01, 1'b0);
        wr(4'h1, 8'h08);
        modem_lines <= 4'h1;
        wait_irq(1'b1);
        rd(4'h2, 8'h00, 1'b0);
        rd(4'h6, 8'h11, 1'b0);
        rd(4'h2, 8'h01, 1'b0);
        wr(4'h1, 8'h00);
        wr(4'h2, 8'h01);
        stall <= 1'b1;
        wr(4'h0, 8'h11);
        wr(4'h0, 8'h22);
        wr(4'h0, 8'h33);
        stall <= 1'b0;
        take_tx(8'h11);
        take_tx(8'h22);
        take_tx(8'h33);
        sb0_link_model_inst.send_rx(8'h81, 3'b000);
        sb0_link_model_inst.send_rx(8'h82, 3'b000);
        rd(4'h0, 8'h81, 1'b0);
        rd(4'h0, 8'h82, 1'b0);
        wr(4'h3, 8'h80);
        rd(4'h0, 8'h00, 1'b1);
        rd(4'h9, 8'h00, 1'b1);
        dma_tx_data <= 8'h77;
        dma_tx_wr <= 1'b1;
        @(posedge pclk);
        dma_tx_wr <= 1'b0;
        take_tx(8'h77);
        sb0_link_model_inst.send_rx(8'h5a, 3'b000);
        dma_rx_rd <= 1'b1;
        @(posedge pclk);
        dma_rx_rd <= 1'b0;
        @(negedge pclk);
        `CHK(dma_rx_data, 8'h5a)
        @(posedge pclk);
        wr(4'h3, 8'h00);
        wr(4'h8, 8'h01);
        wr(4'h4, 8'h04);
        wr(4'h1, 8'h10);
        dma_tc <= 1'b1;
        @(posedge pclk);
        dma_tc <= 1'b0;
        wait_irq(1'b1);
        rd(4'h2, 8'h32, 1'b0);
        wait_irq(1'b0);
        wr(4'h1, 8'h20);
        wait_irq(1'b1);
        end_of_test;
    end
    initial begin
        #20000;
        fails++;
        end_of_test;
    end
endmodule
bind sb0_bank0 sb0_assertions #(.ADDR_W(ADDR_W)) sb0_assertions_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .irq(irq));
